//--- design/dual_gpio_port.v
// dual 8-bit gpio port with change detect behind an avalon-mm slave
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.vh"

module dual_gpio_port (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire        avs_reg_to_reg_move,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        analog_default_cfg,
  input  wire        capture2_pin_select,
  input  wire        single_supply_prog_cfg,
  input  wire        incircuit_debug,
  input  wire [7:0]  first_pin_in,
  output reg  [7:0]  first_pin_out,
  output reg  [7:0]  first_pin_oe,
  output reg  [7:0]  first_pullup_en,
  input  wire [7:0]  second_pin_in,
  output reg  [7:0]  second_pin_out,
  output reg  [7:0]  second_pin_oe,
  input  wire        capture_compare_two_out,
  input  wire        capture_compare_two_out_en,
  input  wire        capture_compare_one_out,
  input  wire        capture_compare_one_out_en,
  input  wire        sck_out,
  input  wire        sck_out_en,
  input  wire        lowfreq_osc_en,
  input  wire [7:0]  second_dir_force_en,
  input  wire [7:0]  second_dir_force_in,
  input  wire        prog_data_out,
  input  wire        prog_data_oe,
  output reg         prog_entry_pin,
  output reg         prog_clock_pin,
  output reg         prog_data_in,
  output reg  [2:0]  ext_irq,
  output reg         pwm_fault_in,
  output reg         capture2_in,
  output reg         timer_count_in,
  output reg         port_change_irq,
  output reg         wake_request
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] first_latch_q;
  reg [7:0] first_dir_q;
  reg [7:0] second_latch_q;
  reg [7:0] second_dir_q;
  reg [7:0] intctl_main_q;
  reg [7:0] intctl_edge_q;
  reg [7:0] intctl_ext_q;
  reg [3:0] analog_pcfg_q;
  reg       strap_done_q;
  reg [7:0] first_s1_q;
  reg [7:0] first_s2_q;
  reg [7:0] second_s1_q;
  reg [7:0] second_s2_q;
  reg [3:0] compare_q;
  reg       access_q;

  wire [3:0] reg_ofs = avs_address[5:2];
  wire       wr_go   = avs_write & access_q;
  wire       rd_go   = avs_read & access_q;
  wire       prog_on = single_supply_prog_cfg | incircuit_debug;

  // analog select: pcfg value 0 means all five low pins analog, any other value none
  function [7:0] analog_mask;
    input [3:0] pcfg;
    begin
      analog_mask = (pcfg == `ANALOG_ALL_LOW) ? `ANALOG_MASK : 8'h00;
    end
  endfunction

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_s1_q  <= 8'h00;
      first_s2_q  <= 8'h00;
      second_s1_q <= 8'h00;
      second_s2_q <= 8'h00;
    end else begin
      first_s1_q  <= first_pin_in;   // [R22]
      first_s2_q  <= first_s1_q;
      second_s1_q <= second_pin_in;
      second_s2_q <= second_s1_q;
    end
  end

  // digital view of pins
  wire [7:0] amask = analog_mask(analog_pcfg_q);
  wire [7:0] first_dig = first_s2_q & ~amask & ~(prog_on ? 8'he0 : 8'h00); // [R15] [R7] [R17]
  wire [7:0] second_dig = second_s2_q & ~(lowfreq_osc_en ? 8'h03 : 8'h00); // [R20]

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  wire [3:0] watch = first_dir_q[7:4] & {~prog_on, ~prog_on, ~prog_on, 1'b1}; // [R8]
  wire       mismatch = |((first_dig[7:4] ^ compare_q) & watch); // [R9]
  wire       first_pins_hit = (rd_go | wr_go) & (reg_ofs == `OFS_FIRST_PINS);
  wire       reload = first_pins_hit & ~avs_reg_to_reg_move; // [R12]
  wire       sw_clr_flag = wr_go & (reg_ofs == `OFS_INTCTL_MAIN)
                           & ~avs_writedata[`BIT_CHANGE_FLAG];

  // ----------------------------------------
  // bus slave and registers
  // ----------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    case (reg_ofs)
      `OFS_FIRST_PINS:   rd_byte = first_dig;       // [R3]
      `OFS_FIRST_LATCH:  rd_byte = first_latch_q;   // [R2]
      `OFS_FIRST_DIR:    rd_byte = first_dir_q;
      `OFS_SECOND_PINS:  rd_byte = second_dig;
      `OFS_SECOND_LATCH: rd_byte = second_latch_q;
      `OFS_SECOND_DIR:   rd_byte = second_dir_q;    // [R18]
      `OFS_INTCTL_MAIN:  rd_byte = intctl_main_q;
      `OFS_INTCTL_EDGE:  rd_byte = intctl_edge_q;
      `OFS_INTCTL_EXT:   rd_byte = intctl_ext_q;
      `OFS_ANALOG_CFG:   rd_byte = {4'h0, analog_pcfg_q};
      default:           rd_byte = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      access_q        <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      access_q        <= (avs_read | avs_write) & ~access_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~access_q);
      if (avs_read & ~access_q)
        avs_readdata <= {24'h000000, rd_byte};
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_latch_q  <= `RST_LATCH;
      first_dir_q    <= `RST_DIR;
      second_latch_q <= `RST_LATCH;
      second_dir_q   <= `RST_DIR;          // [R19]
      intctl_main_q  <= `RST_INTCTL_MAIN;
      intctl_edge_q  <= `RST_INTCTL_EDGE;  // [R6]
      intctl_ext_q   <= `RST_INTCTL_EXT;
      analog_pcfg_q  <= `ANALOG_NONE;
      strap_done_q   <= 1'b0;
      compare_q      <= 4'h0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q)
        analog_pcfg_q <= analog_default_cfg ? `ANALOG_ALL_LOW : `ANALOG_NONE; // [R7]
      else if (wr_go && reg_ofs == `OFS_ANALOG_CFG)
        analog_pcfg_q <= avs_writedata[3:0];
      if (wr_go && (reg_ofs == `OFS_FIRST_PINS || reg_ofs == `OFS_FIRST_LATCH))
        first_latch_q <= avs_writedata[7:0];   // [R3] [R2]
      if (wr_go && reg_ofs == `OFS_FIRST_DIR)
        first_dir_q <= avs_writedata[7:0];
      if (wr_go && (reg_ofs == `OFS_SECOND_PINS || reg_ofs == `OFS_SECOND_LATCH))
        second_latch_q <= avs_writedata[7:0];
      if (wr_go && reg_ofs == `OFS_SECOND_DIR)
        second_dir_q <= avs_writedata[7:0];
      if (wr_go && reg_ofs == `OFS_INTCTL_EDGE)
        intctl_edge_q <= avs_writedata[7:0];   // [R4]
      if (wr_go && reg_ofs == `OFS_INTCTL_EXT)
        intctl_ext_q <= avs_writedata[7:0];
      if (wr_go && reg_ofs == `OFS_INTCTL_MAIN)
        intctl_main_q[7:1] <= avs_writedata[7:1];
      if (reload)
        compare_q <= first_dig[7:4];           // [R11]
      if (mismatch)
        intctl_main_q[`BIT_CHANGE_FLAG] <= 1'b1;  // [R11]
      else if (sw_clr_flag)
        intctl_main_q[`BIT_CHANGE_FLAG] <= 1'b0;  // [R12]
    end
  end

  // ----------------------------------------
  // pin drive and peripheral routing
  // ----------------------------------------
  reg [7:0] f_out_d;
  reg [7:0] f_oe_d;
  reg [7:0] s_out_d;
  reg [7:0] s_oe_d;
  reg [7:0] s_dir_eff;
  always @* begin
    f_out_d = first_latch_q;
    f_oe_d  = ~first_dir_q;                    // [R1]
    if (!capture2_pin_select && capture_compare_two_out_en) begin
      f_out_d[3] = capture_compare_two_out;                   // [R14] [R16]
      f_oe_d[3]  = 1'b1;
    end
    if (prog_on) begin
      f_oe_d[6:5]  = 2'b00;                    // [R17]
      f_oe_d[7]    = prog_data_oe;
      f_out_d[7]   = prog_data_out;
      f_out_d[6:5] = 2'b00;
    end
    s_dir_eff = (second_dir_q & ~second_dir_force_en)
                | (second_dir_force_in & second_dir_force_en); // [R18]
    s_out_d = second_latch_q;
    s_oe_d  = ~s_dir_eff;                      // [R1]
    if (capture2_pin_select && capture_compare_two_out_en) begin
      s_out_d[1] = capture_compare_two_out;                   // [R14] [R16]
      s_oe_d[1]  = 1'b1;
    end
    if (capture_compare_one_out_en) begin
      s_out_d[2] = capture_compare_one_out;                   // [R16]
      s_oe_d[2]  = 1'b1;
    end
    if (sck_out_en) begin
      s_out_d[3] = sck_out;                    // [R16]
      s_oe_d[3]  = 1'b1;
    end
    if (lowfreq_osc_en) begin
      s_oe_d[1:0]  = 2'b00;                    // [R20]
      s_out_d[1:0] = 2'b00;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_pin_out   <= 8'h00;
      first_pin_oe    <= 8'h00;
      first_pullup_en <= 8'h00;
      second_pin_out  <= 8'h00;
      second_pin_oe   <= 8'h00;
      prog_entry_pin  <= 1'b0;
      prog_clock_pin  <= 1'b0;
      prog_data_in    <= 1'b0;
      ext_irq         <= 3'b000;
      pwm_fault_in    <= 1'b0;
      capture2_in     <= 1'b0;
      timer_count_in  <= 1'b0;
      port_change_irq <= 1'b0;
      wake_request    <= 1'b0;
    end else begin
      first_pin_out   <= f_out_d;
      first_pin_oe    <= f_oe_d;
      first_pullup_en <= (intctl_edge_q[`BIT_PULLUP_DIS_N] ? 8'h00 : 8'hff)
                         & first_dir_q & ~(prog_on ? 8'he0 : 8'h00); // [R4] [R5]
      second_pin_out  <= s_out_d;
      second_pin_oe   <= s_oe_d;
      prog_entry_pin  <= prog_on & first_s2_q[5];  // [R17]
      prog_clock_pin  <= prog_on & first_s2_q[6];
      prog_data_in    <= prog_on & first_s2_q[7];
      ext_irq         <= first_dig[2:0] & first_dir_q[2:0]; // [R21]
      pwm_fault_in    <= first_dig[0] & first_dir_q[0];     // [R21]
      capture2_in     <= capture2_pin_select ? second_dig[1] : first_dig[3]; // [R14]
      timer_count_in  <= second_dig[0];
      port_change_irq <= intctl_main_q[`BIT_CHANGE_FLAG]
                         & intctl_main_q[`BIT_CHANGE_IE];
      wake_request    <= intctl_main_q[`BIT_CHANGE_FLAG]
                         & intctl_main_q[`BIT_CHANGE_IE];   // [R10]
    end
  end

endmodule
`default_nettype wire

//--- design/gpio_port_regs.vh
// register map, field positions and reset values of the dual gpio port
// What this block does
// R1 - direction bit 1 makes pin input, high impedance; 0 drives latch value
// R2 - output latch is addressable; reads return the latch, not pins
// R3 - port register read gives pin levels; write updates output latch
// R4 - active-low bit 7 of edge/pullup control enables all first-port pull-ups
// R5 - pull-up of a first-port pin is off while that pin is output; gated by direction bit and prog_on, so first pin 3 driven by capture2 keeps it on
// R6 - power-on reset leaves all first-port pull-ups disabled
// R7 - low five pins reset analog, reading zero, when analog default set
// R8 - change detect watches only upper four first-port pins set as inputs
// R9 - monitored inputs compared with last-read latch; ORed mismatch sets bit 0
// R10 - port change interrupt raises a wake request out of sleep or idle
// R11 - mismatch keeps setting the flag; a port read reloads compare latch
// R12 - any port read or write ends mismatch, except register-to-register move
// R13 - software should not poll the first port while change detect is used
// R14 - capture2 pin select 0 routes channel to first pin 3, 1 to second pin 1
// R15 - analog enabled low pins block digital input but not digital output
// R16 - enabled peripheral outputs take priority over latch data on shared pins
// R17 - programming enable makes upper three pins entry, clock and data only
// R18 - peripherals override second-port direction; direction reads stored value
// R19 - power-on reset makes every second-port pin a digital input
// R20 - timer oscillator enable turns second pins 0,1 into oscillator pins
// R21 - first pins 0..2 feed external interrupts, pin 0 also the pwm fault
// R22 - pin inputs pass a two-stage synchroniser before reads or comparison
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ----------------------------------------
// word offsets (avs_address[5:2])
// ----------------------------------------
`define OFS_FIRST_PINS      4'h0
`define OFS_FIRST_LATCH     4'h1
`define OFS_FIRST_DIR       4'h2
`define OFS_SECOND_PINS     4'h3
`define OFS_SECOND_LATCH    4'h4
`define OFS_SECOND_DIR      4'h5
`define OFS_INTCTL_MAIN     4'h6
`define OFS_INTCTL_EDGE     4'h7
`define OFS_INTCTL_EXT      4'h8
`define OFS_ANALOG_CFG      4'h9

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BIT_CHANGE_FLAG     0
`define BIT_CHANGE_IE       3
`define BIT_PULLUP_DIS_N    7
`define RST_DIR             8'hff
`define RST_LATCH           8'h00
`define RST_INTCTL_MAIN     8'h00
`define RST_INTCTL_EDGE     8'h80
`define RST_INTCTL_EXT      8'h00
`define ANALOG_ALL_LOW      4'h0
`define ANALOG_NONE         4'hf
`define ANALOG_MASK         8'h1f
`define CHANGE_MASK         8'hf0

`endif

//--- dv/pin_world.sv
// pad model for one 8-bit port: driver, outside party, pull-up, float
`timescale 1ns/10ps
`default_nettype none
module pin_world (
  input  wire logic       clk,
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic [7:0]      pad
);
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  // enabled driver wins, then outside party, then pull-up, else wandering
  assign pad = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu)
             | (~oe & ~ext_en & ~pu & {8{tog}});
endmodule
`default_nettype wire

//--- dv/dual_gpio_port_chk.sv
// port-level assertions for the dual gpio port
`timescale 1ns/10ps
`default_nettype none
module dual_gpio_port_chk (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [7:0] first_pin_oe,
  input wire logic [7:0] first_pullup_en,
  input wire logic [7:0] second_pin_oe,
  input wire logic [7:0] second_pin_out,
  input wire logic       capture_compare_one_out,
  input wire logic       capture_compare_one_out_en,
  input wire logic       lowfreq_osc_en,
  input wire logic       port_change_irq,
  input wire logic       wake_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
  AST_PU_OUT: assert property ((first_pullup_en & first_pin_oe) == 8'h00)
    else $error("pull-up on driven pin");
  AST_PU_RST: assert property ($rose(arst_n) |-> first_pullup_en == 8'h00)
    else $error("pull-up on after reset");
  AST_OE_RST: assert property ($rose(arst_n) |-> second_pin_oe == 8'h00)
    else $error("second port driven after reset");
  AST_WAKE: assert property (wake_request == port_change_irq)
    else $error("wake differs from change irq");
  AST_FLAG_HOLD: assert property (port_change_irq && !avs_write && !$past(avs_write)
    |=> port_change_irq)
    else $error("change irq dropped without write");
  AST_CAPTURE_COMPARE_ONE: assert property (capture_compare_one_out_en |=>
    !second_pin_oe[2] || second_pin_out[2] == $past(capture_compare_one_out)) else $error("capture_compare_one lost");
  AST_OSC: assert property (lowfreq_osc_en [*2] |-> second_pin_oe[1:0] == 2'b00)
    else $error("oscillator pins driven");
  cover property (port_change_irq);
  cover property (avs_read && !avs_waitrequest);
  cover property (lowfreq_osc_en ##1 capture_compare_one_out_en);
endmodule
bind dual_gpio_port dual_gpio_port_chk u_chk (.*);
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the dual gpio port
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.vh"
module tb;
  logic        sys_clk = 1'b0, arst_n = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_reg_to_reg_move = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, analog_default_cfg = 1'b1, capture2_pin_select = 1'b1;
  logic        single_supply_prog_cfg = 1'b0, incircuit_debug = 1'b0;
  logic [7:0]  first_pin_in, first_pin_out, first_pin_oe, first_pullup_en;
  logic [7:0]  second_pin_in, second_pin_out, second_pin_oe;
  logic        capture_compare_two_out = 1'b0, capture_compare_two_out_en = 1'b0, capture_compare_one_out = 1'b0, capture_compare_one_out_en = 1'b0;
  logic        sck_out = 1'b0, sck_out_en = 1'b0, lowfreq_osc_en = 1'b0;
  logic [7:0]  second_dir_force_en = 8'h00, second_dir_force_in = 8'h00;
  logic        prog_data_out = 1'b0, prog_data_oe = 1'b0, prog_entry_pin, prog_clock_pin;
  logic        prog_data_in, pwm_fault_in, capture2_in, timer_count_in;
  logic        port_change_irq, wake_request;
  logic [2:0]  ext_irq;
  logic [7:0]  ext_val = 8'hff, rd;
  int          err_count = 0, total_checks = 0, cyc = 0;

  dual_gpio_port u_dual_gpio_port (.*);
  pin_world u_first (.clk(sys_clk), .drv(first_pin_out), .oe(first_pin_oe),
    .pu(first_pullup_en), .ext_val(ext_val), .ext_en(8'hff), .pad(first_pin_in));
  pin_world u_second (.clk(sys_clk), .drv(second_pin_out), .oe(second_pin_oe),
    .pu(8'h00), .ext_val(8'h00), .ext_en(8'h00), .pad(second_pin_in));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task acc(input logic wr, input logic [3:0] idx, input logic [7:0] wd, input logic mv);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_reg_to_reg_move <= mv;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_reg_to_reg_move <= 1'b0;
  endtask

  task st();
    repeat (5) @(posedge sys_clk);
  endtask

  task t_reset();
    logic [3:0] ofs [4] = '{`OFS_FIRST_DIR, `OFS_SECOND_DIR, `OFS_INTCTL_EDGE, `OFS_FIRST_LATCH};
    logic [7:0] exp [4] = '{8'hff, 8'hff, 8'h80, 8'h00};
    chk(first_pullup_en, 8'h00);
    chk(second_pin_oe, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ofs[i], 8'h00, 1'b0);
      chk(rd, exp[i]);
    end
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b0);
    chk(rd, 8'he0);
    acc(1'b0, 4'hf, 8'h00, 1'b0);
    chk(rd, 8'h00);
    $display("reset test done");
  endtask

  task t_port();
    acc(1'b1, `OFS_ANALOG_CFG, 8'h0f, 1'b0);
    acc(1'b1, `OFS_FIRST_LATCH, 8'ha0, 1'b0);
    acc(1'b1, `OFS_FIRST_DIR, 8'h0f, 1'b0);
    ext_val <= 8'h05;
    acc(1'b1, `OFS_INTCTL_EDGE, 8'h00, 1'b0);
    st();
    chk({first_pin_oe, first_pin_out[7:4]}, 12'hf0a);
    chk(first_pullup_en, 8'h0f);
    chk({ext_irq, pwm_fault_in}, 4'hb);
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b0);
    chk(rd, 8'ha5);
    acc(1'b0, `OFS_FIRST_LATCH, 8'h00, 1'b0);
    chk(rd, 8'ha0);
    acc(1'b1, `OFS_FIRST_PINS, 8'h3c, 1'b0);
    acc(1'b1, `OFS_ANALOG_CFG, 8'h00, 1'b0);
    acc(1'b1, `OFS_FIRST_DIR, 8'h00, 1'b0);
    acc(1'b0, `OFS_FIRST_LATCH, 8'h00, 1'b0);
    chk(rd, 8'h3c);
    st();
    chk(first_pin_out, 8'h3c);
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b0);
    chk(rd, 8'h20);
    acc(1'b1, `OFS_INTCTL_EDGE, 8'h80, 1'b0);
    acc(1'b1, `OFS_FIRST_DIR, 8'hff, 1'b0);
    st();
    chk(first_pullup_en, 8'h00);
    $display("port test done");
  endtask

  task t_change();
    ext_val <= 8'h00;
    st();
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b0);
    acc(1'b1, `OFS_INTCTL_MAIN, 8'h08, 1'b0);
    ext_val <= 8'h04;
    st();
    chk(port_change_irq, 1'b0);
    ext_val <= 8'h44;
    st(); // no polling of the first port while watching
    chk({port_change_irq, wake_request}, 2'b11);
    acc(1'b1, `OFS_INTCTL_MAIN, 8'h08, 1'b0);
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b1);
    acc(1'b1, `OFS_INTCTL_MAIN, 8'h08, 1'b0);
    st();
    chk(port_change_irq, 1'b1);
    acc(1'b0, `OFS_FIRST_PINS, 8'h00, 1'b0);
    acc(1'b1, `OFS_INTCTL_MAIN, 8'h08, 1'b0);
    acc(1'b1, `OFS_FIRST_DIR, 8'h7f, 1'b0);
    acc(1'b1, `OFS_FIRST_LATCH, 8'h80, 1'b0);
    st();
    chk(port_change_irq, 1'b0);
    $display("change test done");
  endtask

  task t_periph();
    acc(1'b1, `OFS_SECOND_DIR, 8'h00, 1'b0);
    acc(1'b1, `OFS_FIRST_DIR, 8'hf7, 1'b0);
    capture_compare_one_out_en <= 1'b1;
    capture_compare_one_out <= 1'b1;
    capture_compare_two_out_en <= 1'b1;
    capture_compare_two_out <= 1'b1;
    second_dir_force_en <= 8'h01;
    second_dir_force_in <= 8'h01;
    st();
    chk({second_pin_oe[0], second_pin_out[2:1]}, 3'b011);
    acc(1'b0, `OFS_SECOND_DIR, 8'h00, 1'b0);
    chk(rd, 8'h00);
    capture2_pin_select <= 1'b0;
    lowfreq_osc_en <= 1'b1;
    st();
    chk(first_pin_out[3], 1'b1);
    chk({second_pin_oe[1:0], timer_count_in}, 3'b000);
    incircuit_debug <= 1'b1;
    prog_data_oe <= 1'b1;
    prog_data_out <= 1'b1;
    ext_val <= 8'h40;
    st();
    chk({first_pin_oe[7], first_pin_out[7], prog_clock_pin, prog_data_in, prog_entry_pin},
        5'b11110);
    $display("peripheral test done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_port();
    t_change();
    t_periph();
    print_verdict();
  end
endmodule
`default_nettype wire
